// ===== src/qio_interpolator.sv
// Interpolator back end: configuration registers, hysteresis, scaling and edge stepping.
`timescale 1ns/1ps
module qio_interpolator (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         clk_en,
    input  wire logic [qio_pkg::ANGLE_W-1:0]  angle_in,
    input  wire logic                         angle_valid,
    input  wire logic                         reg_wr,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [7:0]                   reg_wdata,
    output logic      [7:0]                   reg_rdata,
    output logic                              quad_a,
    output logic                              quad_b,
    output logic                              quad_z,
    output logic      [qio_pkg::ANGLE_W-1:0]  pos_word,
    output logic                              pos_valid
);
    import qio_pkg::*;

    logic [1:0]          min_edge_spacing;
    logic [9:0]          interp_factor;
    logic [1:0]          phase_invert_sel;
    logic                direction_invert;
    logic [1:0]          reversal_hysteresis;
    logic [ANGLE_W-1:0]  zero_offset;

    logic                mod_rst;
    qio_state_t          state;

    logic [ANGLE_W-1:0]  rel_angle;
    logic [ANGLE_W-1:0]  hyst_angle;
    logic                last_up;
    logic [ANGLE_W-1:0]  delta;
    logic                moving_up;
    logic [ANGLE_W-1:0]  delta_mag;

    logic [EDGE_W-1:0]   edge_total;
    logic [ANGLE_W-1:0]  next_target;
    logic [ANGLE_W-1:0]  edge_count;
    logic [EDGE_W-1:0]   fwd_dist;
    logic [SPACE_W-1:0]  space_cnt;

    // Edges per rotation is four times the factor, the factor being setting plus one.
    function automatic logic [EDGE_W-1:0] edges_of(input logic [9:0] setting);
        logic [EDGE_W-1:0] f;
        f = {3'b000, setting} + 13'h0001;
        return {f[EDGE_W-3:0], 2'b00};
    endfunction

    // Maps a converter angle onto the edge grid; the floor keeps every edge at a fixed angle.
    function automatic logic [ANGLE_W-1:0] scale_angle(input logic [ANGLE_W-1:0] ang,
                                                       input logic [EDGE_W-1:0] edges);
        logic [24:0] prod;
        prod = {13'h0000, ang} * {12'h000, edges};
        return prod[23:12];
    endfunction

    function automatic logic [ANGLE_W-1:0] hyst_steps(input logic [1:0] sel);
        logic [ANGLE_W-1:0] h;
        case (sel)
            2'h0:    h = HYST_STEPS0;
            2'h1:    h = HYST_STEPS1;
            2'h2:    h = HYST_STEPS2;
            default: h = HYST_STEPS3;
        endcase
        return h;
    endfunction

    function automatic logic [SPACE_W-1:0] spacing_load(input logic [1:0] sel);
        logic [SPACE_W-1:0] c;
        case (sel)
            2'h0:    c = SPACE0_CYC;
            2'h1:    c = SPACE1_CYC;
            2'h2:    c = SPACE2_CYC;
            default: c = SPACE3_CYC;
        endcase
        return c - 9'h001;
    endfunction

    // Register writes.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            min_edge_spacing    <= RST_SPACING;
            interp_factor       <= RST_FACTOR;
            phase_invert_sel    <= RST_INVERT;
            direction_invert    <= RST_DIR;
            reversal_hysteresis <= RST_HYST;
            zero_offset         <= RST_ZERO;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == ADDR_SPACING) begin
                min_edge_spacing <= reg_wdata[SPACE_LSB+1:SPACE_LSB];
            end else if (reg_addr == ADDR_RES_LOW) begin
                interp_factor[7:0] <= reg_wdata;
            end else if (reg_addr == ADDR_OUT_CFG) begin
                interp_factor[9:8]  <= reg_wdata[RES_HI_LSB+1:RES_HI_LSB];
                phase_invert_sel    <= reg_wdata[INV_LSB+1:INV_LSB];
                direction_invert    <= reg_wdata[DIR_BIT];
                reversal_hysteresis <= reg_wdata[HYS_LSB+1:HYS_LSB];
            end else if (reg_addr == ADDR_ZERO_LOW) begin
                zero_offset[7:0] <= reg_wdata;
            end else if (reg_addr == ADDR_ZERO_HI) begin
                zero_offset[11:8] <= reg_wdata[3:0];
            end
        end
    end

    // Register reads; unmapped offsets and unused bits read as zero.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (reg_addr == ADDR_SPACING) begin
                reg_rdata <= {2'b00, min_edge_spacing, 4'h0};
            end else if (reg_addr == ADDR_RES_LOW) begin
                reg_rdata <= interp_factor[7:0];
            end else if (reg_addr == ADDR_OUT_CFG) begin
                reg_rdata <= {reversal_hysteresis, direction_invert, 1'b0, phase_invert_sel, interp_factor[9:8]};
            end else if (reg_addr == ADDR_ZERO_LOW) begin
                reg_rdata <= zero_offset[7:0];
            end else if (reg_addr == ADDR_ZERO_HI) begin
                reg_rdata <= {4'h0, zero_offset[11:8]};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // A write to either resolution or output setting restarts the generator.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mod_rst <= 1'b0;
        end else if (clk_en) begin
            mod_rst <= reg_wr && ((reg_addr == ADDR_RES_LOW) || (reg_addr == ADDR_OUT_CFG));
        end
    end

    // Sequencer: after any reset the absolute position is taken anew before stepping.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= QIO_RESET;
        end else if (clk_en) begin
            if (mod_rst) begin
                state <= QIO_RESET;
            end else begin
                case (state)
                    QIO_RESET: state <= QIO_ALIGN;
                    QIO_ALIGN: begin
                        if (angle_valid) begin
                            state <= QIO_LOAD;
                        end
                    end
                    QIO_LOAD:  state <= QIO_RUN;
                    default:   state <= QIO_RUN;
                endcase
            end
        end
    end

    // Zero shift and direction mirror act before everything, so all outputs share them.
    always_comb begin
        rel_angle = angle_in - zero_offset;
        if (direction_invert) begin
            rel_angle = 12'h000 - rel_angle;
        end
        delta     = rel_angle - hyst_angle;
        moving_up = !delta[ANGLE_W-1];
        delta_mag = moving_up ? delta : (12'h000 - delta);
    end

    // Hysteresis acts on the angle itself, so edges in one direction never move.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hyst_angle <= 12'h000;
            last_up    <= 1'b1;
        end else if (clk_en && angle_valid) begin
            if (state == QIO_ALIGN && !mod_rst) begin
                hyst_angle <= rel_angle;
                last_up    <= 1'b1;
            end else if (state == QIO_RUN && delta != 12'h000) begin
                if (moving_up == last_up) begin
                    hyst_angle <= rel_angle;
                end else if (delta_mag > hyst_steps(reversal_hysteresis)) begin
                    hyst_angle <= rel_angle;
                    last_up    <= moving_up;
                end
            end
        end
    end

    always_comb begin
        edge_total  = edges_of(interp_factor);
        next_target = scale_angle(hyst_angle, edge_total);
        if ({1'b0, next_target} >= {1'b0, edge_count}) begin
            fwd_dist = {1'b0, next_target} - {1'b0, edge_count};
        end else begin
            fwd_dist = {1'b0, next_target} + edge_total - {1'b0, edge_count};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pos_word  <= 12'h000;
            pos_valid <= 1'b0;
        end else if (clk_en) begin
            pos_word  <= next_target;
            pos_valid <= (state == QIO_RUN) && !mod_rst;
        end
    end

    // Edge stepping: one Gray step per event along the shorter way, never faster than the spacing.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            edge_count <= 12'h000;
            space_cnt  <= 9'h000;
        end else if (clk_en) begin
            if (mod_rst || state == QIO_RESET) begin
                edge_count <= 12'h000;
                space_cnt  <= 9'h000;
            end else if (state == QIO_LOAD) begin
                edge_count <= next_target;
                space_cnt  <= spacing_load(min_edge_spacing);
            end else if (state == QIO_RUN) begin
                if (space_cnt != 9'h000) begin
                    space_cnt <= space_cnt - 9'h001;
                end else if (fwd_dist != 13'h0000) begin
                    space_cnt <= spacing_load(min_edge_spacing);
                    if (fwd_dist < {1'b0, edge_total[EDGE_W-1:1]}) begin
                        if ({1'b0, edge_count} == edge_total - 13'h0001) begin
                            edge_count <= 12'h000;
                        end else begin
                            edge_count <= edge_count + 12'h001;
                        end
                    end else begin
                        if (edge_count == 12'h000) begin
                            edge_count <= edge_total[ANGLE_W-1:0] - 12'h001;
                        end else begin
                            edge_count <= edge_count - 12'h001;
                        end
                    end
                end
            end
        end
    end

    qio_quad_out u_quad_out (
        .clk        (clk),
        .resetn     (resetn),
        .clk_en     (clk_en),
        .phase      (edge_count[1:0]),
        .at_zero    (edge_count == 12'h000),
        .hold_high  (state != QIO_RUN),
        .invert_sel (phase_invert_sel),
        .quad_a     (quad_a),
        .quad_b     (quad_b),
        .quad_z     (quad_z)
    );

endmodule // qio_interpolator

// ===== src/qio_pkg.sv
// Constants, register map and state encoding of the quadrature interpolator output block.
package qio_pkg;

    localparam int ANGLE_W = 12;
    localparam int EDGE_W  = 13;
    localparam int SPACE_W = 9;

    localparam logic [7:0] ADDR_SPACING  = 8'h05;
    localparam logic [7:0] ADDR_RES_LOW  = 8'h06;
    localparam logic [7:0] ADDR_OUT_CFG  = 8'h07;
    localparam logic [7:0] ADDR_ZERO_LOW = 8'h08;
    localparam logic [7:0] ADDR_ZERO_HI  = 8'h09;

    localparam int SPACE_LSB = 4;
    localparam int RES_HI_LSB = 0;
    localparam int INV_LSB   = 2;
    localparam int DIR_BIT   = 5;
    localparam int HYS_LSB   = 6;

    localparam logic [1:0]  RST_SPACING   = 2'h2;
    localparam logic [9:0]  RST_FACTOR    = 10'h3FF;
    localparam logic [1:0]  RST_INVERT    = 2'h0;
    localparam logic        RST_DIR       = 1'b0;
    localparam logic [1:0]  RST_HYST      = 2'h0;
    localparam logic [11:0] RST_ZERO      = 12'h000;

    // Hysteresis in converter steps of 360/4096 degrees: 0, 0.17, 0.35, 0.7 degrees.
    localparam logic [11:0] HYST_STEPS0 = 12'h000;
    localparam logic [11:0] HYST_STEPS1 = 12'h002;
    localparam logic [11:0] HYST_STEPS2 = 12'h004;
    localparam logic [11:0] HYST_STEPS3 = 12'h008;

    localparam int CLK_PERIOD_PS = 4000;
    localparam int SPACE0_PS = 52600;
    localparam int SPACE1_PS = 105300;
    localparam int SPACE2_PS = 421100;
    localparam int SPACE3_PS = 1680000;
    localparam logic [SPACE_W-1:0] SPACE0_CYC = SPACE_W'((SPACE0_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [SPACE_W-1:0] SPACE1_CYC = SPACE_W'((SPACE1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [SPACE_W-1:0] SPACE2_CYC = SPACE_W'((SPACE2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [SPACE_W-1:0] SPACE3_CYC = SPACE_W'((SPACE3_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    typedef enum logic [1:0] {
        QIO_RESET = 2'b00,
        QIO_ALIGN = 2'b01,
        QIO_LOAD  = 2'b11,
        QIO_RUN   = 2'b10
    } qio_state_t;

endpackage

// ===== src/qio_quad_out.sv
// Quadrature output stage: Gray phase to A/B, index, inversion and startup hold.
`timescale 1ns/1ps
module qio_quad_out (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    input  wire logic [1:0] phase,
    input  wire logic       at_zero,
    input  wire logic       hold_high,
    input  wire logic [1:0] invert_sel,
    output logic            quad_a,
    output logic            quad_b,
    output logic            quad_z
);
    import qio_pkg::*;

    logic raw_a;
    logic raw_b;

    // Phase 0 is the zero point with both high; rising phase lets B move first.
    always_comb begin
        case (phase)
            2'h0: begin
                raw_a = 1'b1;
                raw_b = 1'b1;
            end
            2'h1: begin
                raw_a = 1'b1;
                raw_b = 1'b0;
            end
            2'h2: begin
                raw_a = 1'b0;
                raw_b = 1'b0;
            end
            default: begin
                raw_a = 1'b0;
                raw_b = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            quad_a <= 1'b1;
            quad_b <= 1'b1;
            quad_z <= 1'b1;
        end else if (clk_en) begin
            if (hold_high) begin
                quad_a <= 1'b1;
                quad_b <= 1'b1;
                quad_z <= 1'b1;
            end else begin
                quad_a <= raw_a ^ invert_sel[1];
                quad_b <= raw_b ^ invert_sel[0];
                quad_z <= at_zero;
            end
        end
    end

endmodule // qio_quad_out

// ===== verif/qio_assertions.sv
// Port-level assertions for the interpolator back end.
`timescale 1ns/1ps
module qio_assertions (
    input wire logic                        clk,
    input wire logic                        resetn,
    input wire logic                        clk_en,
    input wire logic                        reg_wr,
    input wire logic [7:0]                  reg_addr,
    input wire logic [7:0]                  reg_wdata,
    input wire logic [7:0]                  reg_rdata,
    input wire logic                        quad_a,
    input wire logic                        quad_b,
    input wire logic                        quad_z,
    input wire logic [qio_pkg::ANGLE_W-1:0] pos_word,
    input wire logic                        pos_valid
);
    import qio_pkg::*;
    logic [1:0] last_ab;
    logic [8:0] gap;
    logic [1:0] spacing_sel;
    logic [8:0] min_gap;
    logic [2:0] quiet;
    logic       pv_d;
    logic       armed;
    wire        ab_move = ({quad_a, quad_b} != last_ab);
    // Config writes and the jump into run may move the outputs legally, so only steps of a quiet run count.
    always_ff @(posedge clk) begin
        last_ab <= {quad_a, quad_b};
        pv_d    <= pos_valid;
        quiet   <= (!resetn || reg_wr) ? 3'h4 : quiet - {2'h0, quiet != 3'h0};
    end
    always_ff @(posedge clk) begin
        if (!resetn || !pos_valid || !pv_d || quiet != 3'h0) begin
            armed <= 1'b0;
            gap   <= 9'h000;
        end else if (ab_move) begin
            armed <= 1'b1;
            gap   <= 9'h001;
        end else if (gap != 9'h1FF) begin
            gap <= gap + 9'h001;
        end
    end
    // The legal step distance follows the spacing field as the bus writes it, not a fixed worst case.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            spacing_sel <= RST_SPACING;
        end else if (clk_en && reg_wr && reg_addr == ADDR_SPACING) begin
            spacing_sel <= reg_wdata[SPACE_LSB+1:SPACE_LSB];
        end
    end
    always_comb begin
        case (spacing_sel)
            2'h0:    min_gap = SPACE0_CYC;
            2'h1:    min_gap = SPACE1_CYC;
            2'h2:    min_gap = SPACE2_CYC;
            default: min_gap = SPACE3_CYC;
        endcase
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_gray_single: assert property (armed && ab_move |-> ({quad_a, quad_b} ^ last_ab) != 2'h3)
        else $error("both quadrature outputs changed in one step");
    chk_edge_gap: assert property (armed && ab_move |-> gap >= min_gap)
        else $error("quadrature steps closer than the shortest spacing");
    chk_cfg_restart: assert property (clk_en && reg_wr && (reg_addr == ADDR_RES_LOW || reg_addr == ADDR_OUT_CFG)
        ##1 clk_en [*3] |=> !pos_valid && quad_a && quad_b && quad_z)
        else $error("config write did not restart the generator");
    chk_res_readback: assert property (clk_en && reg_wr && reg_addr == ADDR_RES_LOW ##1 clk_en && !reg_wr
        && reg_addr == ADDR_RES_LOW |=> reg_rdata == $past(reg_wdata, 2))
        else $error("factor low byte read back wrong");
    chk_cfg_readback: assert property (clk_en && reg_wr && reg_addr == ADDR_OUT_CFG ##1 clk_en && !reg_wr
        && reg_addr == ADDR_OUT_CFG |=> reg_rdata == ($past(reg_wdata, 2) & 8'hEF))
        else $error("output config read back wrong");
    chk_zero_readback: assert property (clk_en && reg_wr && reg_addr == ADDR_ZERO_HI ##1 clk_en && !reg_wr
        && reg_addr == ADDR_ZERO_HI |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0F))
        else $error("zero offset high read back wrong");
    chk_unmapped_zero: assert property (clk_en && !(reg_addr inside {[ADDR_SPACING:ADDR_ZERO_HI]}) |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    chk_freeze_hold: assert property (!clk_en |=> $stable(pos_word) && $stable(pos_valid) && $stable(quad_z))
        else $error("outputs moved while clock enable low");
endmodule // qio_assertions

// ===== verif/qio_counter_model.sv
// External incremental counter model that follows the quadrature outputs.
`timescale 1ns/1ps
module qio_counter_model (
    input  wire logic        clk,
    input  wire logic        clear,
    input  wire logic        quad_a,
    input  wire logic        quad_b,
    output logic      [15:0] net,
    output logic      [15:0] bad
);
    logic [1:0] last;
    wire  [1:0] now = {~quad_a, quad_a ^ quad_b};
    // Sampling on the system clock is safe because the spacing field keeps steps many cycles apart.
    always_ff @(posedge clk) begin
        last <= now;
        if (clear) begin
            net <= 16'h0000;
            bad <= 16'h0000;
        end else if (now == last + 2'h1) begin
            net <= net + 16'h0001;
        end else if (now == last - 2'h1) begin
            net <= net - 16'h0001;
        end else if (now != last) begin
            bad <= bad + 16'h0001;
        end
    end
endmodule // qio_counter_model

// ===== verif/qio_interpolator_bench.sv
// Self-checking bench: register accesses, angle sweeps and an external counter model.
`timescale 1ns/1ps
module qio_interpolator_bench;
    import qio_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        angle_valid = 1'b1;
    logic        reg_wr = 1'b0;
    logic        clear = 1'b0;
    logic [11:0] angle_in = 12'h000;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        quad_a, quad_b, quad_z, pos_valid;
    logic [11:0] pos_word;
    logic [15:0] net, bad;
    logic [1:0]  s;
    logic [11:0] hys_lsb [4] = '{12'h000, 12'h002, 12'h004, 12'h008};
    logic [7:0]  rst_val [6] = '{8'h20, 8'hFF, 8'h03, 8'h00, 8'h00, 8'h00};
    logic [7:0]  factor_n [3] = '{8'h00, 8'h01, 8'h03};
    int          miscompares = 0;
    int          total_checks = 0;
    int          zhi;

    always #2 clk = ~clk;

    qio_interpolator dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .angle_in(angle_in),
        .angle_valid(angle_valid), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .quad_a(quad_a), .quad_b(quad_b), .quad_z(quad_z),
        .pos_word(pos_word), .pos_valid(pos_valid));
    qio_counter_model partner (.clk(clk), .clear(clear), .quad_a(quad_a), .quad_b(quad_b), .net(net), .bad(bad));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 check("reg_rdata", 16'(reg_rdata), 16'(exp));
    endtask
    task automatic go(input logic [11:0] a, input int n);
        @(posedge clk);
        angle_in <= a;
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Every write to the factor or output config restarts the generator, so wait for run again.
    task automatic restart(input logic [7:0] cfg, input logic [7:0] res);
        int i;
        wr(ADDR_OUT_CFG, cfg);
        wr(ADDR_RES_LOW, res);
        repeat (4) @(posedge clk);
        for (i = 0; i < 50 && pos_valid !== 1'b1; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        #1 check("pos_valid", 16'(pos_valid), 16'h0001);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        #1 check("abz_reset", {12'h000, quad_a, quad_b, quad_z, pos_valid}, 16'h000E);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd(ADDR_SPACING + 8'(i), rst_val[i]);
        go(12'h5A5, 8);
        check("pos_word", 16'(pos_word), 16'h05A5);
        $display("reset test done");
        for (int c = 3; c >= 0; c--) begin
            wr(ADDR_SPACING, 8'hCF | 8'(c << 4));
            rd(ADDR_SPACING, 8'(c << 4));
        end
        $display("spacing test done");
        for (int f = 0; f < 3; f++) begin
            go(12'h000, 1);
            restart(8'h00, factor_n[f]);
            rd(ADDR_RES_LOW, factor_n[f]);
            @(posedge clk);
            clear <= 1'b1;
            @(posedge clk);
            clear <= 1'b0;
            zhi = 0;
            for (int k = 1; k <= 256; k++) begin
                go(12'(k * 16), 20);
                zhi += int'(quad_z);
            end
            check("net_count", net, 16'(4 * (factor_n[f] + 1)));
            check("z_samples", 16'(zhi), 16'(64 / (factor_n[f] + 1)));
            check("skipped_states", bad, 16'h0000);
        end
        $display("sweep test done");
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            go(12'h000, 1);
            restart(8'h10 | {4'h0, s, 2'h0}, 8'h03);
            rd(ADDR_OUT_CFG, {4'h0, s, 2'h0});
            check("abz_zero", {13'h0, quad_a, quad_b, quad_z}, {13'h0, ~s, 1'b1});
            go(12'h12C, 30);
            check("ab_step", {14'h0, quad_a, quad_b}, {14'h0, ~s[1], s[0]});
        end
        $display("inversion test done");
        go(12'h100, 1);
        restart(8'h20, 8'h03);
        check("pos_word", 16'(pos_word), 16'h000F);
        wr(ADDR_ZERO_HI, 8'hF1);
        rd(ADDR_ZERO_HI, 8'h01);
        go(12'h100, 6);
        check("pos_word", 16'(pos_word), 16'h0000);
        wr(ADDR_ZERO_HI, 8'h00);
        wr(ADDR_ZERO_LOW, 8'h80);
        rd(ADDR_ZERO_LOW, 8'h80);
        go(12'h100, 6);
        check("pos_word", 16'(pos_word), 16'h000F);
        wr(ADDR_ZERO_LOW, 8'h00);
        $display("direction test done");
        for (int h = 0; h < 4; h++) begin
            go(12'h064, 1);
            restart({2'(h), 6'h03}, 8'hFF);
            go(12'h06E, 6);
            check("pos_word", 16'(pos_word), 16'h006E);
            go(12'h06E - hys_lsb[h], 6);
            check("pos_word", 16'(pos_word), 16'h006E);
            go(12'h06D - hys_lsb[h], 6);
            check("pos_word", 16'(pos_word), 16'(12'h06D - hys_lsb[h]));
        end
        $display("hysteresis test done");
        @(posedge clk);
        clk_en <= 1'b0;
        go(12'h200, 10);
        check("pos_word_frozen", 16'(pos_word), 16'h0065);
        @(posedge clk);
        clk_en <= 1'b1;
        $display("freeze test done");
        end_of_test;
    end

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        end_of_test;
    end
endmodule // qio_interpolator_bench

bind qio_interpolator qio_assertions chk (.clk(clk), .resetn(resetn), .clk_en(clk_en), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .quad_a(quad_a), .quad_b(quad_b),
    .quad_z(quad_z), .pos_word(pos_word), .pos_valid(pos_valid));
